/* File: logic/htf_hw_config.sv */
// Hardware configuration register with transmit start control and soft reset
`timescale 1ns/1ps
module htf_hw_config
    import htf_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        regWr,
    input  wire logic        regRd,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    output logic      [31:0] regRdata,
    input  wire logic        digitalRst,
    input  wire logic        frameComplete,
    input  wire logic [9:0]  txFifoDwords,
    input  wire logic        txUnderrun,
    input  wire logic        rxErrorIn,
    input  wire logic        frameDone,
    output logic             txStart,
    output logic             softResetOut,
    output logic             txErrorFlag,
    output logic             rxErrorFlag,
    output logic [15:0]      txDataBytes,
    output logic [4:0]       rxSpaceKb,
    output logic [8:0]       thresholdDw
);
    logic          mode_reg;
    logic          storeFwd_reg;
    logic [3:0]    fifoSize_reg;
    logic [1:0]    thrSel_reg;
    logic [2:0]    softRstCnt_reg;
    logic [3:0]    readyCnt_reg;
    logic          ready_reg;
    logic          firstRead_reg;
    htf_tx_state_t state_reg;
    logic          hit;
    logic          wrOk;
    logic          softRstAct;

    // Threshold table lookup
    function automatic logic [8:0] thrLookup(input logic slowMode, input logic [1:0] sel);
        logic [8:0] v;
        v = THR100_0;
        if (slowMode) begin
            case (sel)
                2'h0:    v = THR10_0;
                2'h1:    v = THR10_1;
                2'h2:    v = THR10_2;
                default: v = THR10_3;
            endcase
        end else begin
            case (sel)
                2'h0:    v = THR100_0;
                2'h1:    v = THR100_1;
                2'h2:    v = THR100_2;
                default: v = THR100_3;
            endcase
        end
        return v;
    endfunction : thrLookup

    // Address decode and write qualification
    assign hit        = (regAddr == CONF_OFFSET);
    assign wrOk       = regWr && hit && ready_reg && firstRead_reg;
    assign softRstAct = (softRstCnt_reg != 3'h0);

    // Soft reset pulse counter, self clearing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            softRstCnt_reg <= 3'h0;
        end else if (wrOk && regWdata[SOFT_RST_BIT] && !softRstAct) begin
            softRstCnt_reg <= 3'(SOFT_RST_CYCLES);
        end else if (softRstAct) begin
            softRstCnt_reg <= softRstCnt_reg - 3'h1;
        end
    end
    assign softResetOut = softRstAct || digitalRst;

    // Ready settle counter after any reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readyCnt_reg <= 4'h0;
            ready_reg    <= 1'b0;
        end else if (softResetOut) begin
            readyCnt_reg <= 4'h0;
            ready_reg    <= 1'b0;
        end else if (readyCnt_reg != 4'(READY_CYCLES)) begin
            readyCnt_reg <= readyCnt_reg + 4'h1;
        end else begin
            ready_reg    <= 1'b1;
        end
    end

    // First read tracking; writes wait on one read after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            firstRead_reg <= 1'b0;
        end else if (softResetOut) begin
            firstRead_reg <= 1'b0;
        end else if (regRd && hit) begin
            firstRead_reg <= 1'b1;
        end
    end

    // Configuration fields
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg     <= MODE_RESET;
            storeFwd_reg <= STORE_FWD_RESET;
            fifoSize_reg <= FSZ_RESET;
            thrSel_reg   <= THR_SEL_RESET;
        end else if (softResetOut) begin
            mode_reg     <= MODE_RESET;
            storeFwd_reg <= STORE_FWD_RESET;
            fifoSize_reg <= FSZ_RESET;
            thrSel_reg   <= THR_SEL_RESET;
        end else if (wrOk) begin
            mode_reg     <= regWdata[MODE_BIT];
            storeFwd_reg <= regWdata[STORE_FWD_BIT];
            fifoSize_reg <= regWdata[FSZ_LSB +: 4];
            thrSel_reg   <= regWdata[THR_SEL_LSB +: 2];
        end
    end

    // Error flags: set wins over soft reset clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txErrorFlag <= 1'b0;
            rxErrorFlag <= 1'b0;
        end else begin
            txErrorFlag <= (txUnderrun && state_reg == ST_SEND && !storeFwd_reg) ||
                           (txErrorFlag && !softResetOut);
            rxErrorFlag <= rxErrorIn || (rxErrorFlag && !softResetOut);
        end
    end

    // Transmit start state machine
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else if (softResetOut) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    state_reg <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (storeFwd_reg ? frameComplete
                        : (txFifoDwords >= {1'b0, thrLookup(mode_reg, thrSel_reg)})) begin
                        state_reg <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (frameDone) begin
                        state_reg <= ST_WAIT;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
    assign txStart = (state_reg == ST_SEND);

    // FIFO space split, registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txDataBytes <= 16'h0;
            rxSpaceKb   <= 5'h0;
            thresholdDw <= 9'h0;
        end else begin
            txDataBytes <= {2'h0, fifoSize_reg, 10'h0} - STATUS_BYTES;
            rxSpaceKb   <= TOTAL_KB - {1'b0, fifoSize_reg};
            thresholdDw <= thrLookup(mode_reg, thrSel_reg);
        end
    end

    // Read data; reserved bits zero
    always_comb begin
        regRdata = 32'h0;
        if (hit) begin
            regRdata[READY_BIT]         = ready_reg;
            regRdata[MODE_BIT]          = mode_reg;
            regRdata[STORE_FWD_BIT]     = storeFwd_reg;
            regRdata[FSZ_LSB +: 4]      = fifoSize_reg;
            regRdata[THR_SEL_LSB +: 2]  = thrSel_reg;
            regRdata[SOFT_RST_BIT]      = softRstAct || digitalRst;
        end
    end

    // Checks
    property p_softrst_self_clear;
        @(posedge clk) disable iff (!rst_n)
        (wrOk && regWdata[SOFT_RST_BIT] && !softRstAct && !digitalRst)
            |-> ##[1:5] !softResetOut;
    endproperty
    a_softrst_self_clear: assert property (p_softrst_self_clear)
        else $error("soft reset stuck");
    property p_dig_reads_one;
        @(posedge clk) disable iff (!rst_n) (digitalRst && hit) |-> regRdata[SOFT_RST_BIT];
    endproperty
    a_dig_reads_one: assert property (p_dig_reads_one)
        else $error("soft reset bit not one");
    property p_store_fwd_start;
        @(posedge clk) disable iff (!rst_n)
        (state_reg == ST_WAIT && storeFwd_reg && !frameComplete && !softResetOut)
            |=> state_reg != ST_SEND;
    endproperty
    a_store_fwd_start: assert property (p_store_fwd_start)
        else $error("store and forward started early");
    // Registered threshold lags a field write, so only settled fields count
    property p_thr_start;
        @(posedge clk) disable iff (!rst_n)
        (state_reg == ST_WAIT && !storeFwd_reg && !softResetOut &&
         $stable({mode_reg, thrSel_reg}) && $stable(thresholdDw) &&
         txFifoDwords >= {1'b0, thresholdDw}) |=> txStart;
    endproperty
    a_thr_start: assert property (p_thr_start)
        else $error("no start at threshold");
    // Split is registered: compare with the size one edge earlier
    property p_rx_split;
        @(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> rxSpaceKb == TOTAL_KB - {1'b0, $past(fifoSize_reg)};
    endproperty
    a_rx_split: assert property (p_rx_split)
        else $error("rx split wrong");
    property p_err_clear;
        @(posedge clk) disable iff (!rst_n) (softResetOut && !txUnderrun) |=> !txErrorFlag;
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("tx error not cleared");
    property p_underrun;
        @(posedge clk) disable iff (!rst_n) (txUnderrun && txStart && !storeFwd_reg) |=> txErrorFlag;
    endproperty
    a_underrun: assert property (p_underrun)
        else $error("underrun lost");
    property p_no_write_unready;
        @(posedge clk) disable iff (!rst_n)
        (regWr && hit && !ready_reg) |=> $stable(fifoSize_reg) || softResetOut;
    endproperty
    a_no_write_unready: assert property (p_no_write_unready)
        else $error("write while not ready");
    c_start: cover property (@(posedge clk) disable iff (!rst_n) $rose(txStart));
    c_soft_rst: cover property (@(posedge clk) disable iff (!rst_n) $rose(softResetOut));
    c_ready: cover property (@(posedge clk) disable iff (!rst_n) $rose(ready_reg));
endmodule : htf_hw_config

/* File: logic/htf_pkg.sv */
// Constants for the host transmit FIFO configuration register block
package htf_pkg;
    localparam logic [7:0]  CONF_OFFSET      = 8'h74;  // Register byte address
    localparam int          READY_BIT        = 27;
    localparam int          MODE_BIT         = 21;
    localparam int          STORE_FWD_BIT    = 20;
    localparam int          FSZ_LSB          = 16;
    localparam int          THR_SEL_LSB      = 12;
    localparam int          SOFT_RST_BIT     = 0;
    localparam logic        MODE_RESET       = 1'b0;
    localparam logic        STORE_FWD_RESET  = 1'b0;
    localparam logic [3:0]  FSZ_RESET        = 4'h5;
    localparam logic [1:0]  THR_SEL_RESET    = 2'h0;
    localparam logic [3:0]  FSZ_MIN          = 4'h2;
    localparam logic [3:0]  FSZ_MAX          = 4'he;
    localparam logic [4:0]  TOTAL_KB         = 5'h10;  // Shared buffer in KB
    localparam logic [15:0] STATUS_BYTES     = 16'h0200;
    localparam int          SOFT_RST_CYCLES  = 4;      // Soft reset pulse length
    localparam int          READY_CYCLES     = 8;      // Settle time before ready
    localparam logic [8:0]  THR10_0 = 9'h012;
    localparam logic [8:0]  THR10_1 = 9'h018;
    localparam logic [8:0]  THR10_2 = 9'h020;
    localparam logic [8:0]  THR10_3 = 9'h028;
    localparam logic [8:0]  THR100_0 = 9'h020;
    localparam logic [8:0]  THR100_1 = 9'h040;
    localparam logic [8:0]  THR100_2 = 9'h080;
    localparam logic [8:0]  THR100_3 = 9'h100;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WAIT  = 3'b010,
        ST_SEND  = 3'b100
    } htf_tx_state_t;
endpackage : htf_pkg

/* File: verification/htf_mac_model.sv */
// Transmit side stand-in that fills the FIFO and finishes frames
`timescale 1ns/1ps
module htf_mac_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       fill,
    input  wire logic [9:0] frameLen,
    input  wire logic       txStart,
    output logic      [9:0] txFifoDwords,
    output logic            frameComplete,
    output logic            frameDone
);
    logic [3:0] sendCnt;
    // Whole frame present once the fill reaches its length
    assign frameComplete = (txFifoDwords == frameLen);
    // One DWORD a cycle, emptied when the frame has gone
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txFifoDwords <= 10'h000;
        end else if (frameDone) begin
            txFifoDwords <= 10'h000;
        end else if (fill && !frameComplete) begin
            txFifoDwords <= txFifoDwords + 10'h001;
        end
    end
    // A frame takes eight cycles on the wire
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sendCnt   <= 4'h0;
            frameDone <= 1'b0;
        end else begin
            sendCnt   <= txStart ? sendCnt + 4'h1 : 4'h0;
            frameDone <= (sendCnt == 4'h7);
        end
    end
endmodule : htf_mac_model

/* File: verification/htf_hw_config_bench.sv */
// Self-checking bench for the hardware configuration register
`timescale 1ns/1ps
module htf_hw_config_bench;
    import htf_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, rdVal, rdValW;
    logic        digitalRst = 1'b0, txUnderrun = 1'b0, rxErrorIn = 1'b0, fill = 1'b0;
    logic [9:0]  frameLen = 10'h3ff, txFifoDwords;
    logic        frameComplete, frameDone, txStart, softResetOut, txErrorFlag, rxErrorFlag;
    logic [15:0] txDataBytes;
    logic [4:0]  rxSpaceKb;
    logic [8:0]  thresholdDw;
    logic [8:0]  thr [8] = '{9'h020, 9'h040, 9'h080, 9'h100, 9'h012, 9'h018, 9'h020, 9'h028};
    int          num_errors = 0, num_checks = 0;
    always #20 clk = ~clk;
    htf_hw_config u_htf_hw_config (.clk(clk), .rst_n(rst_n), .regWr(regWr), .regRd(regRd),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(rdValW), .digitalRst(digitalRst),
        .frameComplete(frameComplete), .txFifoDwords(txFifoDwords), .txUnderrun(txUnderrun),
        .rxErrorIn(rxErrorIn), .frameDone(frameDone), .txStart(txStart),
        .softResetOut(softResetOut), .txErrorFlag(txErrorFlag), .rxErrorFlag(rxErrorFlag),
        .txDataBytes(txDataBytes), .rxSpaceKb(rxSpaceKb), .thresholdDw(thresholdDw));
    htf_mac_model u_htf_mac_model (.clk(clk), .rst_n(rst_n), .fill(fill), .frameLen(frameLen),
        .txStart(txStart), .txFifoDwords(txFifoDwords), .frameComplete(frameComplete),
        .frameDone(frameDone));
    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Host reads and writes, one register access each
    task automatic rd(input logic [7:0] a);
        @(posedge clk) begin regRd <= 1'b1; regAddr <= a; end
        @(negedge clk) rdVal = rdValW;
        @(posedge clk) regRd <= 1'b0;
        @(negedge clk);
    endtask : rd
    task automatic wr(input logic [31:0] d);
        @(posedge clk) begin regWr <= 1'b1; regAddr <= CONF_OFFSET; regWdata <= d; end
        @(posedge clk) regWr <= 1'b0;
    endtask : wr
    // Poll until settled; the polls also count as the first read
    task automatic waitReady();
        int n = 0;
        rd(CONF_OFFSET);
        while (rdVal[READY_BIT] !== 1'b1 && n < 60) begin
            rd(CONF_OFFSET);
            n++;
        end
        check("ready", {31'h0, rdVal[READY_BIT]}, 32'h1);
    endtask : waitReady
    // Fill the FIFO and see where transmission starts
    task automatic waitStart(input logic [9:0] t, input logic storeFwd);
        int n = 0;
        @(posedge clk) fill <= 1'b1;
        while (txStart !== 1'b1 && n < 600) begin
            @(negedge clk);
            n++;
        end
        if (storeFwd) check("store fwd start", {22'h0, txFifoDwords}, {22'h0, frameLen});
        else check("thr start", {31'h0, txFifoDwords >= t && txFifoDwords <= t + 3}, 1);
        @(posedge clk) fill <= 1'b0;
    endtask : waitStart
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    // Cut a hang short
    initial begin
        #(40 * 20000);
        num_errors++;
        wrap_up();
    end
    // Main sequence
    initial begin
        int n;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h70); check("unmapped", rdVal, 32'h0);
        rd(CONF_OFFSET); check("reset", rdVal & 32'hf7ffffff, 32'h00050000);
        waitReady();
        check("tx bytes", {16'h0, txDataBytes}, 32'h1200);
        check("rx kb", {27'h0, rxSpaceKb}, 32'hb);
        wr(32'hfffefffe); rd(CONF_OFFSET);
        check("reserved", rdVal, 32'h083e3000);
        check("tx bytes max", {16'h0, txDataBytes}, 32'h3600);
        check("rx kb min", {27'h0, rxSpaceKb}, 32'h2);
        for (int i = 0; i < 8; i++) begin
            wr({10'h0, i[2], 1'b0, 4'h5, 2'h0, i[1:0], 12'h0});
            repeat (2) @(negedge clk);
            check("threshold", {23'h0, thresholdDw}, {23'h0, thr[i]});
        end
        wr(32'h00050000); waitStart(10'h020, 1'b0);
        @(posedge clk) begin txUnderrun <= 1'b1; rxErrorIn <= 1'b1; end
        @(posedge clk) begin txUnderrun <= 1'b0; rxErrorIn <= 1'b0; end
        @(negedge clk) check("tx error", {31'h0, txErrorFlag}, 32'h1);
        check("rx error", {31'h0, rxErrorFlag}, 32'h1);
        n = 0;
        while (txStart !== 1'b0 && n < 50) begin @(negedge clk); n++; end
        @(posedge clk) frameLen <= 10'h030;
        wr(32'h00350000); waitStart(10'h012, 1'b1);
        wr(32'h00350001);
        n = 0;
        repeat (8) begin @(negedge clk); if (softResetOut === 1'b1) n++; end
        check("soft reset len", n, SOFT_RST_CYCLES);
        check("errors clr", {30'h0, txErrorFlag, rxErrorFlag}, 32'h0);
        wr(32'h00003000);
        waitReady(); check("after soft reset", rdVal, 32'h08050000);
        @(posedge clk) digitalRst <= 1'b1;
        rd(CONF_OFFSET); check("digital", {31'h0, rdVal[SOFT_RST_BIT]}, 32'h1);
        check("digital out", {31'h0, softResetOut}, 32'h1);
        @(posedge clk) digitalRst <= 1'b0;
        waitReady();
        wrap_up();
    end
endmodule : htf_hw_config_bench
